// ### adc_serial_config_registers.v
// serial configuration register bank with three-wire write port and readback
//
// Operation
// - all registers zero after any reset
// - one write updates a whole register
// - soft reset bit clears bank, self-clears
// - readback off keeps read pin released
// - readback on drives register contents out
// - swing code decodes to six levels
// - two-bit performance field at 03h
// - mode 00 default, 11 best
// - sample data on falling clock, select low
// - commit every sixteenth edge, address first
// - readback blocks writes, address selects register
`timescale 1ns/1ps
`include "adc_serial_config_regs.vh"

// ----------------------------------------
// notes
// ----------------------------------------
// serial pins are sampled by core_clk through three stages each
// serial clock half period must span at least three core cycles
// a word commits about four core cycles after its 16th falling edge
// decoded outputs follow one core cycle after the commit
// soft reset clears the bank one cycle after its bit is stored
// soft reset wins over a write landing in the same cycle
// readback blocks every write, its own bit included,
// so only a hardware reset leaves readback mode
// unmapped addresses drop writes and read back as zero
// bits that trail a 16-bit multiple are dropped at deselect
// readback data goes msb first: msb after the address, later bits on rising edges
// the read pin shows zero whenever it is released

module adc_serial_config_registers (
  // clock and reset
  input wire core_clk,
  input wire reset,
  // serial port pins
  input wire serial_clk,
  input wire serial_select_n,
  input wire serial_in_line,
  output reg serial_read_out_pin,
  output reg serial_read_out_oe_n,
  // decoded configuration
  output reg [5:0] swing_field,
  output reg [2:0] swing_level,
  output reg swing_override,
  output reg [1:0] perf_boost_field,
  output reg perf_best,
  output reg readback_enabled
);

  localparam NREG = 24;
  // bank indices of the bytes that feed outputs
  localparam IDX_CTRL = 0;
  localparam IDX_SWING = 1;
  localparam IDX_PERF = 3;
  localparam IDX_OVERRIDE = 22;

  // ----------------------------------------
  // address decode
  // ----------------------------------------
  function [4:0] reg_index;
    input [7:0] a;
    begin
      case (a)
        `ADDR_SOFT_RESET_READBACK_CTRL: reg_index = 5'd0;
        `ADDR_OUTPUT_SWING_CODE: reg_index = 5'd1;
        `ADDR_PERF_MODE_E: reg_index = 5'd2;
        `ADDR_PERF_MODE_A: reg_index = 5'd3;
        `ADDR_CHAN_A_GAIN_TESTPAT: reg_index = 5'd4;
        `ADDR_NUMBER_FORMAT_SEL: reg_index = 5'd5;
        `ADDR_CHAN_B_GAIN_TESTPAT: reg_index = 5'd6;
        `ADDR_OFFSET_LOOP_ENABLE: reg_index = 5'd7;
        `ADDR_USER_PATTERN_HIGH: reg_index = 5'd8;
        `ADDR_USER_PATTERN_LOW: reg_index = 5'd9;
        `ADDR_OUTPUT_IFACE_CTRL: reg_index = 5'd10;
        `ADDR_OUTPUT_CLOCK_EDGE_POS: reg_index = 5'd11;
        `ADDR_STANDBY_POWER_STRENGTH: reg_index = 5'd12;
        `ADDR_HIGH_FREQ_MODE_1: reg_index = 5'd13;
        `ADDR_HIGH_FREQ_MODE_2: reg_index = 5'd14;
        `ADDR_CHAN_A_PEDESTAL: reg_index = 5'd15;
        `ADDR_CHAN_B_PEDESTAL: reg_index = 5'd16;
        `ADDR_OFFSET_LOOP_CTRL: reg_index = 5'd17;
        `ADDR_PERF_MODE_B: reg_index = 5'd18;
        `ADDR_PERF_MODE_C: reg_index = 5'd19;
        `ADDR_PERF_MODE_D: reg_index = 5'd20;
        `ADDR_SLOW_RATE_ENABLE: reg_index = 5'd21;
        `ADDR_SWING_OVERRIDE_ENABLE: reg_index = 5'd22;
        `ADDR_SLOW_RATE_CHAN_A: reg_index = 5'd23;
        default: reg_index = 5'd31;
      endcase
    end
  endfunction

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  // settled level: the last stage once the last two stages agree
  function settle;
    input [2:0] stages;
    input held;
    begin
      if (stages[1] == stages[2])
        settle = stages[2];
      else
        settle = held;
    end
  endfunction

  // three stages per pin
  reg [2:0] sclk_sync_reg;
  reg [2:0] sel_sync_reg;
  reg [2:0] din_sync_reg;

  // settled levels
  reg sclk_state_reg;
  reg sel_state_reg;
  reg din_state_reg;

  // serial clock: idle low, so no false edge after reset
  always @(posedge core_clk) begin
    if (reset) begin
      sclk_sync_reg <= 3'h0;
      sclk_state_reg <= 1'b0;
    end else begin
      sclk_sync_reg <= {sclk_sync_reg[1:0], serial_clk};
      sclk_state_reg <= settle(sclk_sync_reg, sclk_state_reg);
    end
  end

  // select: idle high, so the port starts deselected
  always @(posedge core_clk) begin
    if (reset) begin
      sel_sync_reg <= 3'h7;
      sel_state_reg <= 1'b1;
    end else begin
      sel_sync_reg <= {sel_sync_reg[1:0], serial_select_n};
      sel_state_reg <= settle(sel_sync_reg, sel_state_reg);
    end
  end

  // data line: settled copy feeds the shift engine
  always @(posedge core_clk) begin
    if (reset) begin
      din_sync_reg <= 3'h0;
      din_state_reg <= 1'b0;
    end else begin
      din_sync_reg <= {din_sync_reg[1:0], serial_in_line};
      din_state_reg <= settle(din_sync_reg, din_state_reg);
    end
  end

  // edge and level views of the settled pins
  wire sclk_agree = (sclk_sync_reg[1] == sclk_sync_reg[2]);
  wire sclk_fall = sclk_agree && sclk_state_reg && !sclk_sync_reg[2];
  wire sclk_rise = sclk_agree && !sclk_state_reg && sclk_sync_reg[2];
  wire sel_active = !sel_state_reg;
  wire din_bit = settle(din_sync_reg, din_state_reg);

  // ----------------------------------------
  // shift engine
  // ----------------------------------------
  // word shifter, bit count and readback byte
  reg [15:0] shift_reg;
  reg [4:0] bit_cnt_reg;
  reg [7:0] rd_data_reg;

  // every bank byte side by side, eight bits per index
  wire [8*NREG-1:0] bank_flat;

  // byte held at a bank index; unmapped addresses read as zero
  function [7:0] reg_byte;
    input [4:0] i;
    begin
      if (i < NREG)
        reg_byte = bank_flat[i*8 +: 8];
      else
        reg_byte = 8'h00;
    end
  endfunction

  // word and address boundaries, counted on settled falling edges
  wire [15:0] shift_next = {shift_reg[14:0], din_bit};
  wire bit_strobe = sel_active && sclk_fall;
  wire word_done = bit_strobe && (bit_cnt_reg == `WORD_BITS - 5'h01);
  wire addr_done = bit_strobe && (bit_cnt_reg == `ADDR_BITS - 5'h01);
  wire data_phase = (bit_cnt_reg >= `ADDR_BITS);

  // decoded targets of the word being shifted
  wire [4:0] wr_idx = reg_index(shift_next[15:8]);
  wire [4:0] rd_idx = reg_index(shift_next[7:0]);
  wire [7:0] rd_sel_byte = reg_byte(rd_idx);

  // ----------------------------------------
  // bank views
  // ----------------------------------------
  // bytes that drive outputs or control the port
  wire [7:0] ctrl_byte = bank_flat[8*IDX_CTRL +: 8];
  wire [7:0] swing_byte = bank_flat[8*IDX_SWING +: 8];
  wire [7:0] perf_byte = bank_flat[8*IDX_PERF +: 8];
  wire [7:0] override_byte = bank_flat[8*IDX_OVERRIDE +: 8];

  // ----------------------------------------
  // commit control
  // ----------------------------------------
  // writes blocked while readback is on; soft reset from its stored bit
  wire readback_on = ctrl_byte[`BIT_READBACK_EN];
  wire wr_en = word_done && !readback_on;
  wire soft_reset = ctrl_byte[`BIT_SOFT_RESET];

  // shift register takes one bit per settled falling edge
  always @(posedge core_clk) begin
    if (reset)
      shift_reg <= 16'h0000;
    else if (bit_strobe)
      shift_reg <= shift_next;
  end

  // bit counter wraps every word; deselect drops leftover bits
  always @(posedge core_clk) begin
    if (reset)
      bit_cnt_reg <= 5'h00;
    else if (!sel_active)
      bit_cnt_reg <= 5'h00;
    else if (word_done)
      bit_cnt_reg <= 5'h00;
    else if (bit_strobe)
      bit_cnt_reg <= bit_cnt_reg + 5'h01;
  end

  // readback byte: loaded after the address, shifted on each data bit
  always @(posedge core_clk) begin
    if (reset)
      rd_data_reg <= 8'h00;
    else if (addr_done)
      rd_data_reg <= rd_sel_byte;
    else if (bit_strobe && data_phase)
      rd_data_reg <= {rd_data_reg[6:0], 1'b0};
  end

  // ----------------------------------------
  // register storage
  // ----------------------------------------
  // one flip-flop byte per mapped register
  genvar g;
  generate
    for (g = 0; g < NREG; g = g + 1) begin : bank
      reg [7:0] byte_reg;
      // cleared by either reset, else loaded by a matching commit
      always @(posedge core_clk) begin
        if (reset || soft_reset)
          byte_reg <= `REG_RESET_VALUE;
        else if (wr_en && (wr_idx == g))
          byte_reg <= shift_next[7:0];
      end
      assign bank_flat[8*g +: 8] = byte_reg;
    end
  endgenerate

  // ----------------------------------------
  // readback pin
  // ----------------------------------------
  // enable follows the readback bit; high keeps the pin released
  always @(posedge core_clk) begin
    if (reset)
      serial_read_out_oe_n <= 1'b1;
    else
      serial_read_out_oe_n <= !readback_on;
  end

  // msb shows right after the address, later bits change on rising
  // edges so that the controller can latch them on falling edges
  always @(posedge core_clk) begin
    if (reset)
      serial_read_out_pin <= 1'b0;
    else if (!readback_on)
      serial_read_out_pin <= 1'b0;
    else if (addr_done)
      serial_read_out_pin <= rd_sel_byte[7];
    else if (sclk_rise)
      serial_read_out_pin <= rd_data_reg[7];
  end

  // ----------------------------------------
  // decoded outputs
  // ----------------------------------------
  // swing code to level: 0=350 1=410 2=465 3=570 4=200 5=125 mV, 7 unlisted
  function [2:0] swing_decode;
    input [5:0] code;
    begin
      case (code)
        `SWING_350MV: swing_decode = 3'h0;
        `SWING_410MV: swing_decode = 3'h1;
        `SWING_465MV: swing_decode = 3'h2;
        `SWING_570MV: swing_decode = 3'h3;
        `SWING_200MV: swing_decode = 3'h4;
        `SWING_125MV: swing_decode = 3'h5;
        default: swing_decode = 3'h7;
      endcase
    end
  endfunction

  // swing field, its level and the override enable
  always @(posedge core_clk) begin
    if (reset) begin
      swing_field <= 6'h00;
      swing_level <= 3'h0;
      swing_override <= 1'b0;
    end else begin
      swing_field <= swing_byte[`SWING_MSB:`SWING_LSB];
      swing_level <= swing_decode(swing_byte[`SWING_MSB:`SWING_LSB]);
      swing_override <= |override_byte[1:0];
    end
  end

  // performance field and its best-mode flag
  always @(posedge core_clk) begin
    if (reset) begin
      perf_boost_field <= 2'h0;
      perf_best <= 1'b0;
    end else begin
      perf_boost_field <= perf_byte[`PERF_BOOST_MSB:`PERF_BOOST_LSB];
      perf_best <= (perf_byte[`PERF_BOOST_MSB:`PERF_BOOST_LSB] == `PERF_BEST);
    end
  end

  // readback state as a plain level
  always @(posedge core_clk) begin
    if (reset)
      readback_enabled <= 1'b0;
    else
      readback_enabled <= readback_on;
  end

endmodule

// ### adc_serial_config_regs.vh
// register offsets, fields and timing constants of the serial configuration bank
`ifndef ADC_SERIAL_CONFIG_REGS_VH
`define ADC_SERIAL_CONFIG_REGS_VH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define ADDR_SOFT_RESET_READBACK_CTRL 8'h00
`define ADDR_OUTPUT_SWING_CODE 8'h01
`define ADDR_PERF_MODE_E 8'h02
`define ADDR_PERF_MODE_A 8'h03
`define ADDR_CHAN_A_GAIN_TESTPAT 8'h25
`define ADDR_NUMBER_FORMAT_SEL 8'h29
`define ADDR_CHAN_B_GAIN_TESTPAT 8'h2b
`define ADDR_OFFSET_LOOP_ENABLE 8'h3d
`define ADDR_USER_PATTERN_HIGH 8'h3f
`define ADDR_USER_PATTERN_LOW 8'h40
`define ADDR_OUTPUT_IFACE_CTRL 8'h41
`define ADDR_OUTPUT_CLOCK_EDGE_POS 8'h42
`define ADDR_STANDBY_POWER_STRENGTH 8'h45
`define ADDR_HIGH_FREQ_MODE_1 8'h4a
`define ADDR_HIGH_FREQ_MODE_2 8'h58
`define ADDR_CHAN_A_PEDESTAL 8'hbf
`define ADDR_CHAN_B_PEDESTAL 8'hc1
`define ADDR_OFFSET_LOOP_CTRL 8'hcf
`define ADDR_PERF_MODE_B 8'hd5
`define ADDR_PERF_MODE_C 8'hd7
`define ADDR_PERF_MODE_D 8'hdb
`define ADDR_SLOW_RATE_ENABLE 8'hef
`define ADDR_SWING_OVERRIDE_ENABLE 8'hf1
`define ADDR_SLOW_RATE_CHAN_A 8'hf2

// ----------------------------------------
// fields and reset value
// ----------------------------------------
`define REG_RESET_VALUE 8'h00
`define BIT_READBACK_EN 0
`define BIT_SOFT_RESET 1
`define SWING_MSB 7
`define SWING_LSB 2
`define PERF_BOOST_MSB 1
`define PERF_BOOST_LSB 0
`define SWING_350MV 6'h00
`define SWING_410MV 6'h1b
`define SWING_465MV 6'h32
`define SWING_570MV 6'h14
`define SWING_200MV 6'h3e
`define SWING_125MV 6'h0f
`define PERF_DEFAULT 2'h0
`define PERF_BEST 2'h3
`define WORD_BITS 5'h10
`define ADDR_BITS 5'h08

`endif

// ### adc_serial_config_assertions.sv
// checker of the serial configuration bank outputs
`timescale 1ns/1ps
module adc_serial_config_assertions (
  // clock and reset
  input wire core_clk,
  input wire reset,
  // serial port pins
  input wire serial_clk,
  input wire serial_select_n,
  input wire serial_in_line,
  input wire serial_read_out_pin,
  input wire serial_read_out_oe_n,
  // decoded configuration
  input wire [5:0] swing_field,
  input wire [2:0] swing_level,
  input wire swing_override,
  input wire [1:0] perf_boost_field,
  input wire perf_best,
  input wire readback_enabled
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);
  // outputs clear at the first edge after reset release
  property p_rst;
    $fell(reset) |-> swing_field == 6'h00 && perf_boost_field == 2'h0
      && !readback_enabled && serial_read_out_oe_n;
  endproperty
  a_rst: assert property (p_rst) else $error("outputs not cleared by reset");
  // pin released while readback is off
  property p_oe_off;
    !readback_enabled [*2] |-> serial_read_out_oe_n && !serial_read_out_pin;
  endproperty
  a_oe_off: assert property (p_oe_off) else $error("read pin driven while off");
  property p_oe_on;
    readback_enabled [*2] |-> !serial_read_out_oe_n;
  endproperty
  a_oe_on: assert property (p_oe_on) else $error("read pin not driven");
  // best flag follows its field; swing level checked for code 3e only
  property p_best;
    $stable(perf_boost_field) |-> perf_best == (perf_boost_field == 2'h3);
  endproperty
  a_best: assert property (p_best) else $error("best mode decode wrong");
  property p_level;
    $stable(swing_field) && swing_field == 6'h3e |-> swing_level == 3'h4;
  endproperty
  a_level: assert property (p_level) else $error("swing level decode wrong");
  // readback freezes the bank
  property p_ro_block;
    readback_enabled |=> $stable(perf_boost_field) && $stable(swing_field) && readback_enabled;
  endproperty
  a_ro_block: assert property (p_ro_block) else $error("write taken in readback");
  property p_no_sel;
    serial_select_n [*8] |-> $stable(perf_boost_field) && $stable(swing_field);
  endproperty
  a_no_sel: assert property (p_no_sel) else $error("write without select");
  property p_ovr;
    $stable(swing_override) [*2] ##1 $rose(swing_override) |-> !serial_select_n [*1];
  endproperty
  a_ovr: assert property (p_ovr) else $error("override set without select");
  c_rb: cover property (readback_enabled);
  c_best: cover property (perf_best);
  c_odd: cover property (swing_level == 3'h7);
endmodule
bind adc_serial_config_registers adc_serial_config_assertions i_adc_serial_config_assertions (
  .core_clk, .reset, .serial_clk, .serial_select_n, .serial_in_line, .serial_read_out_pin,
  .serial_read_out_oe_n, .swing_field, .swing_level, .swing_override, .perf_boost_field,
  .perf_best, .readback_enabled);

// ### serial_controller_model.sv
// controller model driving the three-wire serial port
`timescale 1ns/1ps
module serial_controller_model (
  // clock
  input wire core_clk,
  // serial port pins
  output logic serial_clk,
  output logic serial_select_n,
  output logic serial_in_line,
  input wire serial_read_out_pin
);
  logic [7:0] rdata;
  // idle: clock still, select high
  initial begin
    serial_clk = 1'b0;
    serial_select_n = 1'b1;
    serial_in_line = 1'b0;
  end
  // n bits msb first; data moves mid-low, readback taken before each fall of bits 8 to 15
  task automatic frame(input logic [39:0] w, input int n);
    @(negedge core_clk);
    serial_select_n = 1'b0;
    for (int i = 0; i < n; i++) begin
      repeat (10) @(negedge core_clk);
      serial_in_line = w[39 - i];
      repeat (10) @(negedge core_clk);
      serial_clk = 1'b1;
      repeat (20) @(negedge core_clk);
      if (i >= 8 && i < 16) rdata = {rdata[6:0], serial_read_out_pin};
      serial_clk = 1'b0;
    end
    repeat (20) @(negedge core_clk);
    serial_select_n = 1'b1;
    serial_in_line = ~serial_in_line;
    // deselect long enough for the settled select to rise
    repeat (8) @(negedge core_clk);
  endtask
endmodule

// ### tb_top.sv
// self-checking bench of the serial configuration bank
`timescale 1ns/1ps
module tb_top;
  logic core_clk = 1'b0;
  logic reset = 1'b1;
  wire serial_clk, serial_select_n, serial_in_line, serial_read_out_pin, serial_read_out_oe_n;
  wire [5:0] swing_field;
  wire [2:0] swing_level;
  wire [1:0] perf_boost_field;
  wire swing_override, perf_best, readback_enabled;
  int err_total = 0;
  int n_checks = 0;
  int cycles = 0;
  int seed = 74;
  int regs [256];
  logic [5:0] codes [6] = '{6'h00, 6'h1b, 6'h32, 6'h14, 6'h3e, 6'h0f};
  logic [5:0] sw;
  initial forever #2 core_clk = ~core_clk;
  adc_serial_config_registers i_adc_serial_config_registers (.core_clk, .reset, .serial_clk,
    .serial_select_n, .serial_in_line, .serial_read_out_pin, .serial_read_out_oe_n,
    .swing_field, .swing_level, .swing_override, .perf_boost_field, .perf_best,
    .readback_enabled);
  serial_controller_model i_serial_controller_model (.core_clk, .serial_clk,
    .serial_select_n, .serial_in_line, .serial_read_out_pin);
  // reference model of a committed word
  function automatic void mw(input int a, input int d);
    if (regs[0] & 1) return;
    if (a == 0 && d[1]) regs = '{default: 0};
    else if (a inside {0, 1, 2, 3, 'h25, 'h29, 'h2b, 'h3d, 'h3f, 'h40, 'h41, 'h42, 'h45,
      'h4a, 'h58, 'hbf, 'hc1, 'hcf, 'hd5, 'hd7, 'hdb, 'hef, 'hf1, 'hf2}) regs[a] = d;
  endfunction
  function automatic int lvl(input int f);
    for (int j = 0; j < 6; j++) if (codes[j] == f) return j;
    return 7;
  endfunction
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string name);
    n_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic cmp_all();
    chk(perf_boost_field, regs[3] & 3, "perf");
    chk(perf_best, (regs[3] & 3) == 3, "best");
    chk(swing_field, regs[1] >> 2, "swing");
    chk(swing_level, lvl(regs[1] >> 2), "level");
    chk(swing_override, (regs['hf1] & 3) != 0, "override");
    chk(readback_enabled, regs[0] & 1, "readback");
    chk(serial_read_out_oe_n, !(regs[0] & 1), "oe_n");
  endtask
  task automatic wr(input int a, input int d);
    i_serial_controller_model.frame({a[7:0], d[7:0], 24'h000000}, 16);
    mw(a, d);
    cmp_all();
  endtask
  task automatic rd(input int a);
    i_serial_controller_model.frame({a[7:0], 32'h00000000}, 16);
    chk(i_serial_controller_model.rdata, regs[a], "readback data");
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // hang guard
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 60000) begin
      err_total++;
      print_verdict();
    end
  end
  // main sequence
  initial begin
    regs = '{default: 0};
    repeat (8) @(negedge core_clk);
    reset = 1'b0;
    repeat (8) @(negedge core_clk);
    cmp_all();
    wr(3, 3);
    wr(3, 0);
    wr('hf1, 3);
    for (int k = 0; k < 6; k++) wr(1, codes[k] << 2);
    sw = $random(seed);
    wr(1, {sw, 2'b00});
    $display("test decode done");
    i_serial_controller_model.frame({8'h03, 8'h03, 8'h01, 8'h78, 8'h03}, 36);
    mw(3, 3);
    mw(1, 'h78);
    cmp_all();
    wr(0, 2);
    wr(3, 3);
    wr(1, 'h6c);
    wr(0, 1);
    rd(3);
    rd(1);
    rd(0);
    rd('h10);
    wr(3, 0);
    $display("test readback done");
    reset = 1'b1;
    repeat (2) @(negedge core_clk);
    reset = 1'b0;
    regs = '{default: 0};
    repeat (2) @(negedge core_clk);
    cmp_all();
    print_verdict();
  end
endmodule
